/* dscg_pkg.sv */
/*
  Shared constants and types for the deep-sleep clock-gate bank.
  Assumes one system clock domain and a byte-addressed register bus.
*/
package dscg_pkg;

  // register byte offsets
  localparam logic [8:0] RUN_GATE_OFS   = 9'h100;
  localparam logic [8:0] SLEEP_GATE_OFS = 9'h110;
  localparam logic [8:0] DEEP_GATE_OFS  = 9'h120;
  localparam logic [8:0] RUN_CFG_OFS    = 9'h130;
  localparam logic [8:0] IRQ_STATUS_OFS = 9'h140;
  localparam logic [8:0] IRQ_MASK_OFS   = 9'h144;

  // gate word layout
  localparam int PWM_BIT       = 20;
  localparam int ADC_BIT       = 16;
  localparam int RATE_MSB      = 9;
  localparam int RATE_LSB      = 8;
  localparam int HIBERNATE_BIT = 6;
  localparam int WATCHDOG_BIT  = 3;

  // gate word reset and writable bits; all else reads zero
  localparam logic [31:0] GATE_RESET    = 32'h00000040;
  localparam logic [31:0] GATE_WRITABLE = 32'h00110348;

  // converter rate codes
  localparam logic [1:0] RATE_125K = 2'h0;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_500K = 2'h2;
  localparam logic [1:0] RATE_MAX  = RATE_500K;

  // run configuration word
  localparam int          AUTO_GATE_BIT  = 0;
  localparam logic [31:0] RUN_CFG_RESET  = 32'h00000000;

  // interrupt status / mask layout
  localparam int          IRQ_WIDTH         = 4;
  localparam int          EV_WATCHDOG_FAULT = 0;
  localparam int          EV_ADC_FAULT      = 1;
  localparam int          EV_PWM_FAULT      = 2;
  localparam int          EV_DEEP_ENTRY     = 3;
  localparam logic [31:0] IRQ_RESET         = 32'h00000000;

  // bus answer codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } dscg_power_mode_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [8:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } dscg_bus_req_type;

  typedef struct packed {
    logic pwm;
    logic adc;
    logic hibernate;
    logic watchdog;
  } dscg_unit_type;

endpackage

/* dscg_gate_reg.sv */
/*
  One byte-writable 32-bit control word with a fixed writable-bit mask.
  Assumes the caller raises wrEn for exactly one cycle per write.
*/
`timescale 1ns/1ps
`default_nettype none
module dscg_gate_reg #(
  parameter logic [31:0] RESET_VALUE = 32'h00000000,
  parameter logic [31:0] WRITABLE    = 32'hffffffff
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // write port
  input  wire logic        wrEn,
  input  wire logic [3:0]  byteEnable,
  input  wire logic [31:0] wrData,
  // stored word
  output logic [31:0]      value
);

  logic [31:0] value_reg;
  logic [31:0] value_next;
  logic [31:0] laneMask;

  // merge enabled lanes; fixed-zero bits never take a one
  always_comb begin
    laneMask = {{8{byteEnable[3]}}, {8{byteEnable[2]}},
                {8{byteEnable[1]}}, {8{byteEnable[0]}}};
    value_next = value_reg;
    if (wrEn) begin
      value_next = (value_reg & ~(laneMask & WRITABLE)) |
                   (wrData & laneMask & WRITABLE);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule
`default_nettype wire

/* dscg_irq.sv */
/*
  Sticky event status with write-one-to-clear, a mask and one level irq.
  Assumes events are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dscg_irq (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // events from the block
  input  wire logic [dscg_pkg::IRQ_WIDTH-1:0] events,
  // software access
  input  wire logic                          clrWrite,
  input  wire logic                          maskWrite,
  input  wire logic [dscg_pkg::IRQ_WIDTH-1:0] wrData,
  // state
  output logic [dscg_pkg::IRQ_WIDTH-1:0]     status,
  output logic [dscg_pkg::IRQ_WIDTH-1:0]     mask,
  output logic                               irq
);

  logic [dscg_pkg::IRQ_WIDTH-1:0] status_reg;
  logic [dscg_pkg::IRQ_WIDTH-1:0] status_next;
  logic [dscg_pkg::IRQ_WIDTH-1:0] mask_reg;
  logic [dscg_pkg::IRQ_WIDTH-1:0] mask_next;
  logic                           irq_reg;
  logic                           irq_next;

  // set wins over clear so an event in the clear cycle survives
  always_comb begin
    status_next = status_reg;
    if (clrWrite) begin
      status_next = status_reg & ~wrData;
    end
    status_next = status_next | events;
    mask_next   = maskWrite ? wrData : mask_reg;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      status_reg <= dscg_pkg::IRQ_RESET[dscg_pkg::IRQ_WIDTH-1:0];
      mask_reg   <= dscg_pkg::IRQ_RESET[dscg_pkg::IRQ_WIDTH-1:0];
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = irq_reg;

endmodule
`default_nettype wire

/* dscg_top.sv */
/*
  Clock-gate bank for four peripheral units: run, sleep and deep-sleep
  gate words, the automatic-gating select, unit bus-fault answers and an
  event interrupt, all behind an Avalon-MM slave with waitrequest.
  Assumes powerMode and unitAccess come from logic on mclk.
*/
// How it works
// R1: a set enable bit drives that unit's clock enable high, a clear bit holds it low.
// R2: an access to a unit other than hibernation whose clock enable is low is answered with a fault pulse.
// R3: unit enables reset to zero except where a reset value says otherwise.
// R4: the gate words reset to 0x00000040, so the hibernation enable comes up set.
// R5: bit 20 of the deep-sleep word gates the pulse-width unit in deep-sleep.
// R6: bit 16 of the deep-sleep word gates converter unit 0 in deep-sleep.
// R7: bit 6 gates the hibernation unit, which never raises a bus fault.
// R8: bit 3 of the deep-sleep word gates the watchdog unit in deep-sleep.
// R9: bits 9:8 pick the converter rate, 2 for 500K, 1 for 250K, 0 for 125K.
// R10: software keeps the rate at or below the part's maximum.
// R11: reserved bits read as zero and ignore writes.
// R12: run, sleep and deep-sleep gate words exist side by side.
// R13: with automatic gating selected, sleep and deep-sleep use their own words.
// R14: otherwise, or in run mode, the run word governs the unit clocks.
`timescale 1ns/1ps
`default_nettype none
module dscg_top (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // register bus
  input  wire dscg_pkg::dscg_bus_req_type    busReq,
  output logic                               busWaitrequest,
  output logic [31:0]                        busReaddata,
  output logic [1:0]                         busResponse,
  // power state from the core
  input  wire dscg_pkg::dscg_power_mode_type powerMode,
  // unit side
  input  wire dscg_pkg::dscg_unit_type       unitAccess,
  output dscg_pkg::dscg_unit_type            unitClockEnable,
  output dscg_pkg::dscg_unit_type            unitFault,
  output logic [1:0]                         sampleRate,
  // interrupt
  output logic                               irq
);

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } dscg_bus_state_type;

  // field extraction used for every gate word
  function automatic dscg_pkg::dscg_unit_type gateOf(input logic [31:0] w);
    dscg_pkg::dscg_unit_type u;
    u.pwm = w[dscg_pkg::PWM_BIT];
    u.adc = w[dscg_pkg::ADC_BIT];
    u.hibernate = w[dscg_pkg::HIBERNATE_BIT];
    u.watchdog  = w[dscg_pkg::WATCHDOG_BIT];
    return u;
  endfunction

  // address compare shared by read and write decode
  function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
    return a == ofs;
  endfunction

  // bus state
  dscg_bus_state_type busState_reg;
  dscg_bus_state_type busState_next;
  logic               wait_reg;
  logic               wait_next;
  logic [31:0]        readdata_reg;
  logic [31:0]        readdata_next;
  logic [1:0]         response_reg;
  logic [1:0]         response_next;
  logic               commit;
  logic               mapped;

  // stored words
  logic [31:0] runGate;
  logic [31:0] sleepGate;
  logic [31:0] deepGate;
  logic [31:0] runCfg;
  logic [dscg_pkg::IRQ_WIDTH-1:0] irqStatus;
  logic [dscg_pkg::IRQ_WIDTH-1:0] irqMask;
  logic [dscg_pkg::IRQ_WIDTH-1:0] events;

  // unit side state
  dscg_pkg::dscg_unit_type clkEn_reg;
  dscg_pkg::dscg_unit_type clkEn_next;
  dscg_pkg::dscg_unit_type fault_reg;
  dscg_pkg::dscg_unit_type fault_next;
  logic [1:0]              rate_reg;
  logic [1:0]              rate_next;
  logic                    deep_reg;
  logic                    deep_next;
  logic [31:0]             activeGate;
  logic [1:0]              rawRate;

  // writes land only in the cycle waitrequest is low
  assign commit = (busState_reg == BUS_ANSWER) && busReq.write;

  // bus answer machine: one wait cycle, then one answer cycle
  always_comb begin
    busState_next = busState_reg;
    wait_next     = 1'b1;
    readdata_next = readdata_reg;
    response_next = response_reg;
    mapped = hit(busReq.address, dscg_pkg::RUN_GATE_OFS) ||
             hit(busReq.address, dscg_pkg::SLEEP_GATE_OFS) ||
             hit(busReq.address, dscg_pkg::DEEP_GATE_OFS) ||
             hit(busReq.address, dscg_pkg::RUN_CFG_OFS) ||
             hit(busReq.address, dscg_pkg::IRQ_STATUS_OFS) ||
             hit(busReq.address, dscg_pkg::IRQ_MASK_OFS);
    case (busState_reg)
      BUS_IDLE: begin
        if (busReq.read || busReq.write) begin
          busState_next = BUS_ANSWER;
          wait_next     = 1'b0;
          response_next = mapped ? dscg_pkg::RESP_OKAY : dscg_pkg::RESP_DECERR;
          readdata_next = 32'h00000000;
          // reserved bits are already zero in every stored word
          if (busReq.read) begin // [R11]
            case (1'b1)
              hit(busReq.address, dscg_pkg::RUN_GATE_OFS):   readdata_next = runGate;
              hit(busReq.address, dscg_pkg::SLEEP_GATE_OFS): readdata_next = sleepGate;
              hit(busReq.address, dscg_pkg::DEEP_GATE_OFS):  readdata_next = deepGate;
              hit(busReq.address, dscg_pkg::RUN_CFG_OFS):    readdata_next = runCfg;
              hit(busReq.address, dscg_pkg::IRQ_STATUS_OFS): begin
                readdata_next = {28'h0000000, irqStatus};
              end
              hit(busReq.address, dscg_pkg::IRQ_MASK_OFS): begin
                readdata_next = {28'h0000000, irqMask};
              end
              default: readdata_next = 32'h00000000;
            endcase
          end
        end
      end
      BUS_ANSWER: begin
        busState_next = BUS_IDLE;
        wait_next     = 1'b1;
      end
      default: begin
        busState_next = BUS_IDLE;
        wait_next     = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busState_reg <= BUS_IDLE;
      wait_reg     <= 1'b1;
      readdata_reg <= 32'h00000000;
      response_reg <= dscg_pkg::RESP_OKAY;
    end else begin
      busState_reg <= busState_next;
      wait_reg     <= wait_next;
      readdata_reg <= readdata_next;
      response_reg <= response_next;
    end
  end

  // three parallel gate words, reset to the whole-word value
  dscg_gate_reg #( // [R12] [R3] [R4]
    .RESET_VALUE (dscg_pkg::GATE_RESET),
    .WRITABLE    (dscg_pkg::GATE_WRITABLE)
  ) runGateReg (
    .mclk       (mclk),
    .reset      (reset),
    .wrEn       (commit && hit(busReq.address, dscg_pkg::RUN_GATE_OFS)),
    .byteEnable (busReq.byteenable),
    .wrData     (busReq.writedata),
    .value      (runGate)
  );

  dscg_gate_reg #( // [R12] [R3] [R4]
    .RESET_VALUE (dscg_pkg::GATE_RESET),
    .WRITABLE    (dscg_pkg::GATE_WRITABLE)
  ) sleepGateReg (
    .mclk       (mclk),
    .reset      (reset),
    .wrEn       (commit && hit(busReq.address, dscg_pkg::SLEEP_GATE_OFS)),
    .byteEnable (busReq.byteenable),
    .wrData     (busReq.writedata),
    .value      (sleepGate)
  );

  // only bits 20, 16, 9:8, 6 and 3 can ever hold a one
  dscg_gate_reg #( // [R12] [R3] [R4] [R11]
    .RESET_VALUE (dscg_pkg::GATE_RESET),
    .WRITABLE    (dscg_pkg::GATE_WRITABLE)
  ) deepGateReg (
    .mclk       (mclk),
    .reset      (reset),
    .wrEn       (commit && hit(busReq.address, dscg_pkg::DEEP_GATE_OFS)),
    .byteEnable (busReq.byteenable),
    .wrData     (busReq.writedata),
    .value      (deepGate)
  );

  // run configuration: holds the automatic-gating select
  dscg_gate_reg #(
    .RESET_VALUE (dscg_pkg::RUN_CFG_RESET),
    .WRITABLE    (32'h00000001 << dscg_pkg::AUTO_GATE_BIT)
  ) runCfgReg (
    .mclk       (mclk),
    .reset      (reset),
    .wrEn       (commit && hit(busReq.address, dscg_pkg::RUN_CFG_OFS)),
    .byteEnable (busReq.byteenable),
    .wrData     (busReq.writedata),
    .value      (runCfg)
  );

  // pick the governing word, drive clocks, rate and fault answers
  always_comb begin
    activeGate = runGate; // [R14]
    if (runCfg[dscg_pkg::AUTO_GATE_BIT]) begin // [R13]
      case (powerMode)
        dscg_pkg::MODE_SLEEP: activeGate = sleepGate;
        dscg_pkg::MODE_DEEP:  activeGate = deepGate;
        default:              activeGate = runGate;
      endcase
    end
    // bits 20, 16, 6, 3 map to pwm, converter, hibernation, watchdog enables
    clkEn_next = gateOf(activeGate); // [R1] [R5] [R6] [R7] [R8]
    rawRate = activeGate[dscg_pkg::RATE_MSB:dscg_pkg::RATE_LSB];
    // code 3 has no rate; hold it to the top rate rather than guess
    rate_next = (rawRate > dscg_pkg::RATE_MAX) ? dscg_pkg::RATE_MAX : rawRate; // [R9] [R10]
    // fault judged against the clock state the unit really has now
    fault_next.pwm = unitAccess.pwm && !clkEn_reg.pwm; // [R2]
    fault_next.adc = unitAccess.adc && !clkEn_reg.adc; // [R2]
    fault_next.hibernate = 1'b0; // [R7]
    fault_next.watchdog  = unitAccess.watchdog && !clkEn_reg.watchdog; // [R2]
    deep_next = (powerMode == dscg_pkg::MODE_DEEP);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      clkEn_reg <= gateOf(dscg_pkg::GATE_RESET); // [R3] [R4]
      fault_reg <= '0;
      rate_reg  <= dscg_pkg::RATE_125K;
      deep_reg  <= 1'b0;
    end else begin
      clkEn_reg <= clkEn_next;
      fault_reg <= fault_next;
      rate_reg  <= rate_next;
      deep_reg  <= deep_next;
    end
  end

  // events: unit faults and entry into deep-sleep
  always_comb begin
    events = '0;
    events[dscg_pkg::EV_WATCHDOG_FAULT] = fault_next.watchdog;
    events[dscg_pkg::EV_ADC_FAULT]  = fault_next.adc;
    events[dscg_pkg::EV_PWM_FAULT]  = fault_next.pwm;
    events[dscg_pkg::EV_DEEP_ENTRY] = deep_next && !deep_reg;
  end

  dscg_irq irqBank (
    .mclk      (mclk),
    .reset     (reset),
    .events    (events),
    .clrWrite  (commit && hit(busReq.address, dscg_pkg::IRQ_STATUS_OFS) &&
                busReq.byteenable[0]),
    .maskWrite (commit && hit(busReq.address, dscg_pkg::IRQ_MASK_OFS) &&
                busReq.byteenable[0]),
    .wrData    (busReq.writedata[dscg_pkg::IRQ_WIDTH-1:0]),
    .status    (irqStatus),
    .mask      (irqMask),
    .irq       (irq)
  );

  // outputs straight from flops
  assign busWaitrequest  = wait_reg;
  assign busReaddata     = readdata_reg;
  assign busResponse     = response_reg;
  assign unitClockEnable = clkEn_reg;
  assign unitFault       = fault_reg;
  assign sampleRate      = rate_reg;

endmodule
`default_nettype wire

/* dscg_top_assertions.sv */
/*
  Concurrent checks for the clock-gate bank top.
  Bound to dscg_top below; sees its ports only, single mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dscg_top_assertions (
  // clock and reset
  input wire logic                          mclk,
  input wire logic                          reset,
  // register bus
  input wire dscg_pkg::dscg_bus_req_type    busReq,
  input wire logic                          busWaitrequest,
  input wire logic [31:0]                   busReaddata,
  input wire logic [1:0]                    busResponse,
  // unit side
  input wire dscg_pkg::dscg_power_mode_type powerMode,
  input wire dscg_pkg::dscg_unit_type       unitAccess,
  input wire dscg_pkg::dscg_unit_type       unitClockEnable,
  input wire dscg_pkg::dscg_unit_type       unitFault,
  input wire logic [1:0]                    sampleRate,
  input wire logic                          irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  logic [2:0] quietReg;
  logic [2:0] quietNext;
  logic [1:0] modeReg;
  logic       mapped;

  // cycles since the last write or mode change, saturating at 7
  always_comb begin
    quietNext = (quietReg == 3'h7) ? quietReg : quietReg + 3'h1;
    if (busReq.write || (powerMode != modeReg)) begin
      quietNext = 3'h0;
    end
  end

  // registered helper state
  always_ff @(posedge mclk) begin
    quietReg <= reset ? 3'h0 : quietNext;
    modeReg  <= powerMode;
  end

  // decode of the six mapped words
  assign mapped = busReq.address inside {dscg_pkg::RUN_GATE_OFS, dscg_pkg::SLEEP_GATE_OFS,
    dscg_pkg::DEEP_GATE_OFS, dscg_pkg::RUN_CFG_OFS, dscg_pkg::IRQ_STATUS_OFS,
    dscg_pkg::IRQ_MASK_OFS};

  sequence reqIdle;
    (busReq.read || busReq.write) && busWaitrequest;
  endsequence
  sequence oneAnswer;
    !busWaitrequest ##1 busWaitrequest;
  endsequence

  a_bus_answer: assert property (reqIdle |=> oneAnswer)
    else $error("bus answer not a single cycle after the request");
  a_unmapped_read: assert property (reqIdle and busReq.read && !mapped |=>
    busResponse == dscg_pkg::RESP_DECERR && busReaddata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (reqIdle and mapped |=> busResponse == dscg_pkg::RESP_OKAY)
    else $error("mapped access not answered okay");
  a_fault_answer: assert property (1'b1 |=> unitFault ==
    ($past(unitAccess) & ~$past(unitClockEnable) & 4'b1101))
    else $error("unit fault does not match gated access");
  a_hibernate_quiet: assert property (!unitFault[1])
    else $error("hibernation unit raised a fault");
  a_rate_legal: assert property (sampleRate != 2'h3)
    else $error("sample rate above the maximum code");
  a_gate_quiet: assert property (quietReg >= 3'h3 |-> $stable(unitClockEnable) &&
    $stable(sampleRate))
    else $error("unit clocks changed without a write or mode change");
  a_reset_state: assert property ($fell(reset) |-> unitClockEnable == 4'b0010 &&
    sampleRate == 2'h0 && !irq && busWaitrequest)
    else $error("outputs wrong after reset");
endmodule

bind dscg_top dscg_top_assertions u_dscg_top_assertions (.mclk(mclk), .reset(reset),
  .busReq(busReq), .busWaitrequest(busWaitrequest), .busReaddata(busReaddata),
  .busResponse(busResponse), .powerMode(powerMode), .unitAccess(unitAccess),
  .unitClockEnable(unitClockEnable), .unitFault(unitFault), .sampleRate(sampleRate),
  .irq(irq));
`default_nettype wire

/* dscg_top_tb.sv */
/*
  Self-checking bench for the clock-gate bank top.
  Drives every port itself over Avalon-MM; no partner model.
*/
`timescale 1ns/1ps
`default_nettype none
module dscg_top_tb;
  logic                          mclk;
  logic                          reset;
  dscg_pkg::dscg_bus_req_type    busReq;
  logic                          busWaitrequest;
  logic [31:0]                   busReaddata;
  logic [1:0]                    busResponse;
  dscg_pkg::dscg_power_mode_type powerMode;
  dscg_pkg::dscg_unit_type       unitAccess;
  dscg_pkg::dscg_unit_type       unitClockEnable;
  dscg_pkg::dscg_unit_type       unitFault;
  logic [1:0]                    sampleRate;
  logic                          irq;
  int                            failCount;
  int                            numChecks;
  logic [33:0]                   expQ [$];
  logic [31:0]                   gw [3];
  logic [31:0]                   word;
  logic [31:0]                   lane;
  logic [3:0]                    be;

  dscg_top u_dscg_top (.mclk(mclk), .reset(reset), .busReq(busReq),
    .busWaitrequest(busWaitrequest), .busReaddata(busReaddata), .busResponse(busResponse),
    .powerMode(powerMode), .unitAccess(unitAccess), .unitClockEnable(unitClockEnable),
    .unitFault(unitFault), .sampleRate(sampleRate), .irq(irq));

  // 25 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic testDone();
    if (failCount == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one bus cycle, entered just after an edge; holds until waitrequest is seen low
  task automatic busCycle(input logic wr, input logic [8:0] a, input logic [3:0] b,
                          input logic [31:0] d);
    int n;
    n = 0;
    busReq.read       <= ~wr;
    busReq.write      <= wr;
    busReq.address    <= a;
    busReq.byteenable <= b;
    busReq.writedata  <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (busWaitrequest !== 1'b0 && n < 50);
    if (n == 50) begin
      failCount++;
      $display("BAD %0t no bus answer", $time);
    end
    busReq.read  <= 1'b0;
    busReq.write <= 1'b0;
    @(posedge mclk); // idle edge keeps requests three cycles apart
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] b);
    busCycle(1'b1, a, b, d);
  endtask

  task automatic rd(input logic [8:0] a, input logic [1:0] r, input logic [31:0] d);
    expQ.push_back({r, d});
    busCycle(1'b0, a, 4'hf, 32'h0);
  endtask

  // takes the oldest note at each read answer
  always @(posedge mclk) begin
    if (busReq.read && busWaitrequest === 1'b0) begin
      if (expQ.size() == 0) begin
        failCount++;
        $display("BAD %0t read answer with no expected value", $time);
      end else begin
        check({busResponse, busReaddata}, expQ.pop_front());
      end
    end
  end

  // hang guard, far beyond the fewer than two hundred cycles of the run
  initial begin
    repeat (5000) @(posedge mclk);
    failCount++;
    $display("BAD %0t run timed out", $time);
    testDone();
  end

  // main sequence
  initial begin
    word = $urandom(32'h1818d9cd);
    reset = 1'b1;
    busReq = '0;
    powerMode = dscg_pkg::MODE_RUN;
    unitAccess = '0;
    failCount = 0;
    numChecks = 0;
    for (int j = 0; j < 3; j++) begin
      gw[j] = dscg_pkg::GATE_RESET;
    end
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check(34'(unitClockEnable), 34'h2);
    // reset values of the mapped words
    for (int i = 0; i < 3; i++) begin
      rd(dscg_pkg::RUN_GATE_OFS + 9'(16 * i), 2'h0, dscg_pkg::GATE_RESET);
    end
    rd(dscg_pkg::RUN_CFG_OFS, 2'h0, 32'h0);
    rd(dscg_pkg::IRQ_STATUS_OFS, 2'h0, 32'h0);
    rd(dscg_pkg::IRQ_MASK_OFS, 2'h0, 32'h0);
    // random lanes into each gate word; reserved bits must read zero
    for (int i = 0; i < 9; i++) begin
      word = $urandom();
      // random rate field kept at or below the top code, as software must
      word[8] = word[8] & ~word[9];
      be = 4'($urandom());
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      gw[i % 3] = (gw[i % 3] & ~lane) | (word & lane & dscg_pkg::GATE_WRITABLE);
      wr(dscg_pkg::RUN_GATE_OFS + 9'(16 * (i % 3)), word, be);
      rd(dscg_pkg::RUN_GATE_OFS + 9'(16 * (i % 3)), 2'h0, gw[i % 3]);
    end
    // unmapped place: write ignored, read refused
    wr(9'h124, 32'hffffffff, 4'hf);
    rd(9'h124, dscg_pkg::RESP_DECERR, 32'h0);
    rd(dscg_pkg::DEEP_GATE_OFS, 2'h0, gw[2]);
    // run word cleared, so without auto gating all clocks stay off
    wr(dscg_pkg::RUN_GATE_OFS, 32'h0, 4'hf);
    wr(dscg_pkg::SLEEP_GATE_OFS, 32'h00100040, 4'hf);
    powerMode <= dscg_pkg::MODE_DEEP;
    repeat (3) @(posedge mclk);
    check(34'(unitClockEnable), 34'h0);
    wr(dscg_pkg::RUN_CFG_OFS, 32'h1, 4'hf);
    // one unit at a time in deep-sleep, each rate code; code 3 clamps to 2
    for (int k = 0; k < 4; k++) begin
      word = (k == 0) ? 32'h00100000 : (k == 1) ? 32'h00010000 : (k == 2) ? 32'h40 : 32'h8;
      wr(dscg_pkg::DEEP_GATE_OFS, word | (32'(k) << 8), 4'hf);
      repeat (3) @(posedge mclk);
      check(34'({sampleRate, unitClockEnable}), 34'({(k == 3) ? 2'h2 : 2'(k), 4'b1000 >> k}));
    end
    powerMode <= dscg_pkg::MODE_SLEEP;
    repeat (3) @(posedge mclk);
    check(34'({sampleRate, unitClockEnable}), 34'h0a);
    powerMode <= dscg_pkg::MODE_RUN;
    repeat (3) @(posedge mclk);
    check(34'(unitClockEnable), 34'h0);
    // gated access faults and raises the interrupt; clear the deep entry event first
    wr(dscg_pkg::IRQ_STATUS_OFS, 32'hf, 4'h1);
    wr(dscg_pkg::IRQ_MASK_OFS, 32'hf, 4'h1);
    check(34'(irq), 34'h0);
    unitAccess <= 4'b1111;
    @(posedge mclk);
    unitAccess <= 4'b0000;
    #1 check(34'(unitFault), 34'hd);
    @(posedge mclk);
    repeat (3) @(posedge mclk);
    check(34'(irq), 34'h1);
    rd(dscg_pkg::IRQ_STATUS_OFS, 2'h0, 32'h7);
    wr(dscg_pkg::IRQ_MASK_OFS, 32'h0, 4'h1);
    repeat (2) @(posedge mclk);
    check(34'(irq), 34'h0);
    wr(dscg_pkg::IRQ_STATUS_OFS, 32'h7, 4'h1);
    wr(dscg_pkg::IRQ_MASK_OFS, 32'hf, 4'h1);
    repeat (2) @(posedge mclk);
    check(34'(irq), 34'h0);
    // clocked units answer without a fault
    wr(dscg_pkg::RUN_GATE_OFS, 32'h00110048, 4'hf);
    repeat (3) @(posedge mclk);
    unitAccess <= 4'b1111;
    @(posedge mclk);
    unitAccess <= 4'b0000;
    #1 check(34'(unitFault), 34'h0);
    @(posedge mclk);
    // second reset in mid-run restores the word
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(dscg_pkg::RUN_GATE_OFS, 2'h0, dscg_pkg::GATE_RESET);
    testDone();
  end
endmodule
`default_nettype wire
